// >>> design/eac_access_control.sv
// EEPROM access control: registers, arming, timing, stalls
`timescale 1ns/1ps
`include "eac_cfg.svh"
module eac_access_control
  import eac_pkg::*;
#(
  parameter int PROG_CYCLES  = `EAC_PROG_RC_CYCLES,
  parameter int SPLIT_CYCLES = `EAC_SPLIT_RC_CYCLES,
  parameter int RC_DIV       = `EAC_RC_DIV
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] ioAddr,
  input  wire logic       ioWrEn,
  input  wire logic       ioRdEn,
  input  wire logic [7:0] ioWrData,
  input  wire logic       selfProgActive,
  output logic      [7:0] ioRdData,
  output logic            cpuStall,
  output logic            readyIrq
);
  eac_state_t s_reg;       // Current state
  eac_state_t s_next;      // Next state
  logic [7:0] memRdData;   // Array byte at current address
  logic       armBit;      // Arm bit as software sees it
  logic       busy;        // Program strobe as software sees it
  logic       rcTick;      // One RC oscillator cycle elapsed
  logic       ctrlWr;      // Control register write
  logic       readGo;      // Read accepted
  logic       progGo;      // Program accepted
  logic       progDone;    // Last RC cycle of program

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  function automatic logic isReg(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  assign armBit   = s_reg.armCnt != 3'h0;
  assign busy     = s_reg.phase == EAC_PROG;
  assign rcTick   = s_reg.divCnt == 4'(RC_DIV - 1);
  assign ctrlWr   = ioWrEn && isReg(ioAddr, `EAC_OFF_CTRL);
  // Program wins over read in one write; refused while busy or flash busy
  assign progGo   = ctrlWr && ioWrData[`EAC_BIT_PROG] && armBit && !busy
                    && !selfProgActive && s_reg.mode != `EAC_MODE_RSVD;
  assign readGo   = ctrlWr && ioWrData[`EAC_BIT_READ] && !busy && !progGo;
  assign progDone = busy && rcTick && s_reg.progCnt == 15'h1;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_next        = s_reg;
    s_next.memWr  = 1'b0;
    // RC oscillator tick divider
    s_next.divCnt = rcTick ? 4'h0 : s_reg.divCnt + 4'h1;
    // Arm window counts down
    if (armBit)
    begin
      s_next.armCnt = s_reg.armCnt - 3'h1;
    end
    // Stall countdown
    if (s_reg.stallCnt != 3'h0)
    begin
      s_next.stallCnt = s_reg.stallCnt - 3'h1;
    end
    // Read data lands one cycle after the strobe
    s_next.readPend = 1'b0;
    if (s_reg.readPend)
    begin
      s_next.data = memRdData;
    end
    // Register writes
    if (ioWrEn)
    begin
      if (isReg(ioAddr, `EAC_OFF_DATA))
      begin
        s_next.data = ioWrData;
      end
      // Address frozen while programming
      if (isReg(ioAddr, `EAC_OFF_ADDRL) && !busy)
      begin
        s_next.addr[7:0] = ioWrData;
      end
      if (isReg(ioAddr, `EAC_OFF_ADDRH) && !busy)
      begin
        s_next.addr[10:8] = ioWrData[2:0];
      end
    end
    if (ctrlWr)
    begin
      s_next.rie = ioWrData[`EAC_BIT_RIE];
      // Mode writes ignored while busy
      if (!busy)
      begin
        s_next.mode = ioWrData[`EAC_BIT_MODE1:`EAC_BIT_MODE0];
      end
      // Arm only when strobe written zero
      if (ioWrData[`EAC_BIT_ARM] && !ioWrData[`EAC_BIT_PROG])
      begin
        s_next.armCnt = `EAC_ARM_WINDOW;
      end
    end
    // Read strobe
    if (readGo)
    begin
      s_next.readPend = 1'b1;
      s_next.stallCnt = `EAC_STALL_READ;
    end
    // Program sequencer
    case (s_reg.phase)
      EAC_IDLE:
      begin
        if (progGo)
        begin
          s_next.phase    = EAC_PROG;
          s_next.armCnt   = 3'h0;
          s_next.progData = s_reg.data;
          s_next.stallCnt = `EAC_STALL_PROG;
          s_next.progCnt  = (s_reg.mode == `EAC_MODE_ATOMIC)
                            ? 15'(PROG_CYCLES) : 15'(SPLIT_CYCLES);
        end
      end
      EAC_PROG:
      begin
        if (rcTick)
        begin
          s_next.progCnt = s_reg.progCnt - 15'h1;
        end
        if (progDone)
        begin
          s_next.phase = EAC_IDLE;
          s_next.memWr = 1'b1;
          case (s_reg.mode)
            `EAC_MODE_ERASE: s_next.memWrData = `EAC_ERASED;
            `EAC_MODE_WRITE: s_next.memWrData = memRdData & s_reg.progData;
            default:         s_next.memWrData = s_reg.progData;
          endcase
        end
      end
      default:
      begin
        s_next.phase = EAC_IDLE;
      end
    endcase
    s_next.stall = s_next.stallCnt != 3'h0;
    // Ready interrupt: enabled, strobe clear, flash idle
    s_next.irq = s_next.rie && s_next.phase == EAC_IDLE && !selfProgActive;
    // Registered bus read data
    s_next.rdData = `EAC_ZERO8;
    if (ioRdEn)
    begin
      if (isReg(ioAddr, `EAC_OFF_CTRL))
      begin
        s_next.rdData = {2'h0, s_reg.mode, s_reg.rie, armBit, busy, 1'b0};
      end
      else if (isReg(ioAddr, `EAC_OFF_DATA))
      begin
        s_next.rdData = s_reg.data;
      end
      else if (isReg(ioAddr, `EAC_OFF_ADDRL))
      begin
        s_next.rdData = s_reg.addr[7:0];
      end
      else if (isReg(ioAddr, `EAC_OFF_ADDRH))
      begin
        s_next.rdData = {5'h00, s_reg.addr[10:8]};
      end
    end
  end

  // ----------------------------------------
  // State register, synchronous reset
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign ioRdData = s_reg.rdData;
  assign cpuStall = s_reg.stall;
  assign readyIrq = s_reg.irq;

  // ----------------------------------------
  // EEPROM byte array
  // ----------------------------------------
  eac_nvm_array #(
    .DEPTH (2048),
    .AW    (11)
  ) u_array (
    .clk    (clk),
    .wrEn   (s_reg.memWr),
    .addr   (s_reg.addr),
    .wrData (s_reg.memWrData),
    .rdData (memRdData)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  arm_window_a: assert property ($rose(armBit) && !ctrlWr ##1 !ctrlWr[*3] |=> !armBit)
    else $error("arm bit not cleared after four cycles");
  no_prog_unarmed_a: assert property (!busy ##1 busy |-> $past(armBit))
    else $error("programming started without arm");
  prog_start_a: assert property (progGo |=> busy ##0 s_reg.armCnt == 3'h0)
    else $error("armed strobe did not start programming");
  prog_stall_a: assert property ($rose(busy) |-> cpuStall[*2] ##1 !cpuStall)
    else $error("program stall not two cycles");
  read_stall_a: assert property (readGo |=> cpuStall[*4] ##1 !cpuStall)
    else $error("read stall not four cycles");
  read_data_a: assert property (readGo |=> ##1 s_reg.data == $past(memRdData))
    else $error("read data not loaded");
  addr_lock_a: assert property (busy |=> $stable(s_reg.addr))
    else $error("address changed while programming");
  mode_lock_a: assert property (busy |=> $stable(s_reg.mode))
    else $error("mode changed while programming");
  busy_hold_a: assert property (busy && !progDone |=> busy)
    else $error("program strobe dropped early");
  prog_end_a: assert property (progDone |=> !busy ##0 s_reg.memWr)
    else $error("program end not signalled");
  // Same-cycle check: the interrupt may rise in the cycle after the last busy cycle
  irq_quiet_a: assert property (busy |-> !readyIrq)
    else $error("ready interrupt during programming");

  prog_done_c: cover property (progDone);
  read_seen_c: cover property (readGo ##5 !cpuStall);
  arm_expire_c: cover property (armBit ##1 !armBit && !busy);
  erase_mode_c: cover property (progDone && s_reg.mode == `EAC_MODE_ERASE);
endmodule

// >>> common/eac_cfg.svh
// Constants for the EEPROM access control block
`ifndef EAC_CFG_SVH
`define EAC_CFG_SVH
// Register offsets on the I/O bus
`define EAC_OFF_CTRL   8'h3F
`define EAC_OFF_DATA   8'h40
`define EAC_OFF_ADDRL  8'h41
`define EAC_OFF_ADDRH  8'h42
// Control register bit positions
`define EAC_BIT_READ   0
`define EAC_BIT_PROG   1
`define EAC_BIT_ARM    2
`define EAC_BIT_RIE    3
`define EAC_BIT_MODE0  4
`define EAC_BIT_MODE1  5
// Timing counts in clk cycles
`define EAC_ARM_WINDOW 3'h4
`define EAC_STALL_PROG 3'h2
`define EAC_STALL_READ 3'h4
// Program mode codes
`define EAC_MODE_ATOMIC 2'h0
`define EAC_MODE_ERASE  2'h1
`define EAC_MODE_WRITE  2'h2
`define EAC_MODE_RSVD   2'h3
// Data values
`define EAC_ERASED     8'hFF
`define EAC_ZERO8      8'h00
// Program times in RC oscillator cycles
`define EAC_PROG_RC_CYCLES  26368
`define EAC_SPLIT_RC_CYCLES 13184
// clk cycles per RC oscillator cycle
`define EAC_RC_DIV     12
`endif

// >>> common/eac_pkg.sv
// Types for the EEPROM access control block
package eac_pkg;
  // Sequencer phase
  typedef enum logic {EAC_IDLE, EAC_PROG} eac_phase_t;
  // Whole state of the control block
  typedef struct packed {
    eac_phase_t  phase;     // Idle or programming
    logic [10:0] addr;      // Byte address
    logic [7:0]  data;      // Data register
    logic [7:0]  progData;  // Byte latched at program start
    logic [1:0]  mode;      // Program mode field
    logic        rie;       // Ready interrupt enable
    logic [2:0]  armCnt;    // Arm window countdown
    logic [2:0]  stallCnt;  // Stall countdown
    logic        stall;     // Stall output
    logic        readPend;  // Capture read data next cycle
    logic [14:0] progCnt;   // RC cycles left
    logic [3:0]  divCnt;    // RC tick divider
    logic [7:0]  rdData;    // Bus read data
    logic        irq;       // Ready interrupt output
    logic        memWr;     // Array write strobe
    logic [7:0]  memWrData; // Array write value
  } eac_state_t;
endpackage

// >>> design/eac_nvm_array.sv
// Byte array holding the EEPROM contents
`timescale 1ns/1ps
module eac_nvm_array #(
  parameter int DEPTH = 2048,
  parameter int AW    = 11
) (
  input  wire logic          clk,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wrData,
  output logic      [7:0]    rdData
);
  logic [7:0] mem [DEPTH];  // Storage

  // ----------------------------------------
  // Registered read, single write port
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[addr] <= wrData;
    end
    rdData <= mem[addr];
  end
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the EEPROM access control block
`timescale 1ns/1ps
`include "eac_cfg.svh"
module tb_top
  import eac_pkg::*;
;
  // ----------------------------------------
  // Signals and mode table
  // ----------------------------------------
  logic       clk, reset_n, ioWrEn, ioRdEn, selfProgActive;
  logic [7:0] ioAddr, ioWrData, ioRdData, q;
  logic       cpuStall, readyIrq, rie;
  logic [1:0] mode;
  int         numErrors, checkCount;
  localparam logic [1:0] MT [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  localparam logic [7:0] DT [4] = '{8'h00, 8'h0F, 8'h00, 8'h5A};
  localparam logic [7:0] ET [4] = '{8'hFF, 8'h0F, 8'h0F, 8'h5A};
  localparam int         CT [4] = '{13, 13, 0, 29};

  // Short timing so the program count stays small
  eac_access_control #(.PROG_CYCLES(16), .SPLIT_CYCLES(8), .RC_DIV(2)) u_eac_access_control (
    .clk(clk), .reset_n(reset_n), .ioAddr(ioAddr), .ioWrEn(ioWrEn), .ioRdEn(ioRdEn),
    .ioWrData(ioWrData), .selfProgActive(selfProgActive), .ioRdData(ioRdData),
    .cpuStall(cpuStall), .readyIrq(readyIrq));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // Bus tasks and checks
  // ----------------------------------------
  task automatic stopTest();
    $display("errors %0d checks %0d", numErrors, checkCount);
    if (numErrors == 0 && checkCount > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checkCount++;
    if (got !== exp)
    begin
      numErrors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One bus cycle, launched just after an edge
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    ioWrEn = w;
    ioRdEn = r;
    ioAddr = a;
    ioWrData = d;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    acc(1'b0, 1'b1, a, 8'h00);
    v = ioRdData;
  endtask
  function automatic logic [7:0] cv(input logic [2:0] b);
    return {2'h0, mode, rie, b};
  endfunction
  // Load, arm, then gap idles (no arm if negative), strobe
  task automatic start(input logic [10:0] a, input logic [7:0] d, input int gap, input logic ok);
    logic [7:0] v;
    acc(1'b1, 1'b0, `EAC_OFF_ADDRL, a[7:0]);
    acc(1'b1, 1'b0, `EAC_OFF_ADDRH, {5'h00, a[10:8]});
    acc(1'b1, 1'b0, `EAC_OFF_DATA, d);
    if (gap >= 0)
      acc(1'b1, 1'b0, `EAC_OFF_CTRL, cv(3'h4));
    repeat (gap > 0 ? gap : 0) acc(1'b0, 1'b0, 8'h00, 8'h00);
    acc(1'b1, 1'b0, `EAC_OFF_CTRL, cv(3'h2));
    chk("progStall1", {7'h00, ok}, {7'h00, cpuStall});
    rd(`EAC_OFF_CTRL, v);
    chk("progStall2", {7'h00, ok}, {7'h00, cpuStall});
    chk("busyBit", {7'h00, ok}, {7'h00, v[`EAC_BIT_PROG]});
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    chk("progStallEnd", 8'h00, {7'h00, cpuStall});
    if (ok)
      chk("irqBusy", 8'h00, {7'h00, readyIrq});
  endtask
  // Poll busy to zero and check the elapsed count
  task automatic finish(input int cyc);
    logic [7:0] v;
    int         n;
    v = 8'h02;
    n = 0;
    while (v[`EAC_BIT_PROG] && n < 200)
    begin
      rd(`EAC_OFF_CTRL, v);
      n++;
    end
    if (v[`EAC_BIT_PROG])
    begin
      numErrors++;
      $display("MISMATCH busyTimeout expected 00 seen 02");
      stopTest();
    end
    if (cyc > 0)
      chk("progTime", 8'h01, {7'h00, (n >= cyc - 4) && (n <= cyc + 4)});
    repeat (2) acc(1'b0, 1'b0, 8'h00, 8'h00);
    chk("readyIrq", {7'h00, rie & ~selfProgActive}, {7'h00, readyIrq});
  endtask
  // Read strobe, four stall cycles, then data register
  task automatic eeread(input logic [10:0] a, input logic setA, input logic [7:0] exp);
    logic [7:0] v;
    if (setA)
    begin
      acc(1'b1, 1'b0, `EAC_OFF_ADDRL, a[7:0]);
      acc(1'b1, 1'b0, `EAC_OFF_ADDRH, {5'h00, a[10:8]});
    end
    acc(1'b1, 1'b0, `EAC_OFF_CTRL, cv(3'h1));
    for (int i = 0; i < 5; i++)
    begin
      chk("readStall", {7'h00, i < 4}, {7'h00, cpuStall});
      acc(1'b0, 1'b0, 8'h00, 8'h00);
    end
    rd(`EAC_OFF_DATA, v);
    chk("readData", exp, v);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    reset_n = 1'b0;
    ioWrEn = 1'b0;
    ioRdEn = 1'b0;
    ioAddr = 8'h00;
    ioWrData = 8'h00;
    selfProgActive = 1'b0;
    numErrors = 0;
    checkCount = 0;
    mode = 2'h0;
    rie = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    rd(`EAC_OFF_CTRL, q);
    chk("ctrlReset", 8'h00, q);
    chk("irqReset", 8'h00, {7'h00, readyIrq});
    rd(8'h10, q);
    chk("unmapped", 8'h00, q);
    rie = 1'b1;
    // Top and bottom address, window edge, late and missing arm
    start(11'h7FF, 8'hA5, 0, 1'b1);
    finish(29);
    eeread(11'h7FF, 1'b1, 8'hA5);
    start(11'h000, 8'h3C, 3, 1'b1);
    finish(29);
    start(11'h000, 8'h99, 4, 1'b0);
    finish(0);
    start(11'h000, 8'h99, -1, 1'b0);
    finish(0);
    eeread(11'h000, 1'b1, 8'h3C);
    // Arm bit reads one through the fourth cycle only
    acc(1'b1, 1'b0, `EAC_OFF_CTRL, cv(3'h4));
    repeat (3) acc(1'b0, 1'b0, 8'h00, 8'h00);
    rd(`EAC_OFF_CTRL, q);
    chk("armHeld", cv(3'h4), q);
    rd(`EAC_OFF_CTRL, q);
    chk("armCleared", cv(3'h0), q);
    // Every mode code, reserved one refused
    for (int k = 0; k < 4; k++)
    begin
      mode = MT[k];
      start(11'h155, DT[k], 0, MT[k] != 2'h3);
      finish(CT[k]);
      eeread(11'h155, 1'b1, ET[k]);
    end
    // Flash programming blocks a start
    selfProgActive = 1'b1;
    start(11'h155, 8'h00, 0, 1'b0);
    finish(0);
    selfProgActive = 1'b0;
    // Address, mode and read locked out while busy
    start(11'h155, 8'h11, 0, 1'b1);
    acc(1'b1, 1'b0, `EAC_OFF_ADDRL, 8'h00);
    acc(1'b1, 1'b0, `EAC_OFF_CTRL, {4'h2, rie, 3'h0});
    rd(`EAC_OFF_CTRL, q);
    chk("modeLocked", cv(3'h2), q);
    acc(1'b1, 1'b0, `EAC_OFF_CTRL, cv(3'h1));
    chk("readLocked", 8'h00, {7'h00, cpuStall});
    rd(`EAC_OFF_ADDRL, q);
    chk("addrLocked", 8'h55, q);
    rd(`EAC_OFF_DATA, q);
    chk("readLockData", 8'h11, q);
    finish(25);
    eeread(11'h155, 1'b0, 8'h11);
    stopTest();
  end
endmodule
